// *** logic/vrmc_ctrl.sv ***
// Mode control of the voltage conversion routine with its Avalon-MM register slave.
`timescale 1ns/1ns
`default_nettype none
module vrmc_ctrl #(
  parameter int LEN_W    = 24,
  parameter int PER_W    = 24,
  parameter int BASE_CYC = vrmc_pkg::WIN_BASE_CYC,
  parameter int GSET_CYC = vrmc_pkg::GSET_CYC,
  parameter int CSET_CYC = vrmc_pkg::CSET_CYC,
  parameter int BSET_CYC = vrmc_pkg::BSET_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Fault validation request
  input  wire logic        ovr_req_i,
  // Routine progress
  output logic             active_o,
  output logic [3:0]       seg_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (PER_W != 24 || LEN_W < 16 || BASE_CYC < 1 || GSET_CYC < 1 || CSET_CYC < 1
      || BSET_CYC < 1 || (longint'(BASE_CYC) * 128) >= (longint'(1) << LEN_W)) begin : g_chk
    $error("vrmc_ctrl: parameter values out of range");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    vrmc_pkg::vrmc_mode_t st;
    logic [3:0]           seg;
    logic                 start;
    logic                 latch;
    logic                 cyc_en;
    logic                 cyc_off_pend;
    logic                 locked;
    logic                 active;
    logic                 tick_pend;
    logic [2:0]           od_sel;
    logic [2:0]           cy_sel;
    logic [4:0]           cy_opts;
    logic [2:0]           run_sel;
    logic [4:0]           run_opts;
    logic [PER_W-1:0]     period;
    logic                 waitreq;
    logic [31:0]          rdata;
  } vrmc_st_t;

  vrmc_st_t         s_r;
  vrmc_st_t         s_nxt;
  logic             tload;
  logic [LEN_W-1:0] tlen;
  logic             tdone;
  logic             pexp;
  logic [3:0]       nx;
  logic             req;
  logic             acc;
  logic [31:0]      ctrl_img;
  logic [31:0]      rd_mux;
  logic [31:0]      bmask;
  logic [31:0]      wv;

  function automatic logic [LEN_W-1:0] win(input logic [2:0] sel);
    return LEN_W'(BASE_CYC) << sel;
  endfunction : win

  function automatic logic [LEN_W-1:0] seg_len(input logic [3:0] idx, input logic [2:0] sel);
    logic [LEN_W-1:0] r;
    r = LEN_W'(BASE_CYC);
    unique case (vrmc_pkg::seg_kind(idx))
      vrmc_pkg::K_SEL:   r = win(sel);
      vrmc_pkg::K_SHORT: r = LEN_W'(BASE_CYC);
      vrmc_pkg::K_GSET:  r = LEN_W'(GSET_CYC);
      vrmc_pkg::K_CSET:  r = LEN_W'(CSET_CYC);
      vrmc_pkg::K_BSET:  r = LEN_W'(BSET_CYC);
    endcase
    return r;
  endfunction : seg_len

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  vrmc_win_tmr #(.LEN_W(LEN_W)) u_win (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .load_i  (tload),
    .len_i   (tlen),
    .done_o  (tdone)
  );

  // The period runs only while cyclic mode is enabled and not locked, so
  // enabling it again always starts a fresh period from zero.
  vrmc_period_tmr #(.W(PER_W)) u_per (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .run_i    (s_r.cyc_en && !s_r.locked),
    .period_i (s_r.period),
    .expire_o (pexp)
  );

  // ----------------------------------------------------------------
  // Register images
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_img = '0;
    ctrl_img[vrmc_pkg::CTRL_START]        = s_r.start;
    ctrl_img[vrmc_pkg::CTRL_LATCH]        = s_r.latch;
    ctrl_img[vrmc_pkg::CTRL_CYC]          = s_r.cyc_en;
    ctrl_img[vrmc_pkg::CTRL_ACTIVE]       = s_r.active;
    ctrl_img[vrmc_pkg::CTRL_ODSEL+:3]     = s_r.od_sel;
    ctrl_img[vrmc_pkg::CTRL_CYSEL+:3]     = s_r.cy_sel;
    ctrl_img[vrmc_pkg::CTRL_OPTS+:5]      = s_r.run_opts;
    ctrl_img[vrmc_pkg::CTRL_CYOPTS+:5]    = s_r.cy_opts;
    rd_mux = '0;
    unique case (avs_address_i)
      vrmc_pkg::OFF_CTRL:   rd_mux = ctrl_img;
      vrmc_pkg::OFF_PERIOD: rd_mux[PER_W-1:0] = s_r.period;
      vrmc_pkg::OFF_INFO:   rd_mux[vrmc_pkg::INFO_LOCK:0] = {s_r.locked, s_r.seg};
      default:              rd_mux = '0;
    endcase
    for (int b = 0; b < 4; b++) begin
      bmask[8*b+:8] = {8{avs_byteenable_i[b]}};
    end
  end

  assign req = avs_read_i || avs_write_i;
  assign acc = req && !s_r.waitreq;
  assign wv  = avs_writedata_i & bmask;
  assign nx  = vrmc_pkg::next_seg(s_r.seg, s_r.run_opts);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    tload = 1'b0;
    tlen  = seg_len(4'h0, s_r.run_sel);

    // One wait cycle per access; readdata is captured as waitrequest drops.
    s_nxt.waitreq = !(req && s_r.waitreq);
    if (req && s_r.waitreq) begin
      s_nxt.rdata = avs_read_i ? rd_mux : 32'h0000_0000;
    end

    if (acc && avs_write_i && avs_address_i == vrmc_pkg::OFF_PERIOD) begin
      s_nxt.period = (s_r.period & ~bmask[PER_W-1:0]) | wv[PER_W-1:0];
    end

    if (acc && avs_write_i && avs_address_i == vrmc_pkg::OFF_CTRL) begin
      if (avs_byteenable_i[0]) begin
        s_nxt.od_sel = avs_writedata_i[vrmc_pkg::CTRL_ODSEL+:3];
      end
      if (avs_byteenable_i[1]) begin
        s_nxt.cy_sel = avs_writedata_i[vrmc_pkg::CTRL_CYSEL+:3];
      end
      if (avs_byteenable_i[2]) begin
        s_nxt.cy_opts = avs_writedata_i[vrmc_pkg::CTRL_CYOPTS+:5];
      end
      // Clearing the latch is refused while an override runs or cyclic is locked.
      if (wv[vrmc_pkg::CTRL_LATCH] && s_r.st != vrmc_pkg::M_OVR && !s_r.locked) begin
        s_nxt.latch = 1'b0;
      end
      if (avs_byteenable_i[0]) begin
        if (avs_writedata_i[vrmc_pkg::CTRL_CYC]) begin
          s_nxt.cyc_off_pend = 1'b0;
          if (!s_r.cyc_en) begin
            s_nxt.cyc_en    = 1'b1;
            s_nxt.tick_pend = 1'b1;
          end
        end else if (s_r.cyc_en) begin
          // Disable waits for the active phase so the flag never dangles.
          if (s_r.active) begin
            s_nxt.cyc_off_pend = 1'b1;
          end else begin
            s_nxt.cyc_en    = 1'b0;
            s_nxt.locked    = 1'b0;
            s_nxt.tick_pend = 1'b0;
          end
        end
      end
      // Start is taken only from idle: never over a running on-demand or override.
      if (wv[vrmc_pkg::CTRL_START] && !s_r.start && s_r.st == vrmc_pkg::M_IDLE) begin
        s_nxt.st       = vrmc_pkg::M_OD;
        s_nxt.start    = 1'b1;
        s_nxt.active   = 1'b1;
        s_nxt.seg      = 4'h0;
        s_nxt.run_sel  = s_nxt.od_sel;
        s_nxt.run_opts = avs_byteenable_i[1] ? avs_writedata_i[vrmc_pkg::CTRL_OPTS+:5]
                                             : vrmc_pkg::OPTS_RST;
        tload = 1'b1;
        tlen  = seg_len(4'h0, s_nxt.od_sel);
      end
    end

    // Cyclic launch; a period that expires during a run is kept for its end.
    if (pexp) begin
      s_nxt.tick_pend = 1'b1;
    end
    if ((s_r.tick_pend || pexp) && s_r.st == vrmc_pkg::M_IDLE && s_nxt.st == vrmc_pkg::M_IDLE
        && s_nxt.cyc_en && !s_r.locked && !s_nxt.cyc_off_pend) begin
      s_nxt.st        = vrmc_pkg::M_CYC;
      s_nxt.active    = 1'b1;
      s_nxt.tick_pend = 1'b0;
      s_nxt.seg       = 4'h0;
      s_nxt.run_sel   = s_nxt.cy_sel;
      s_nxt.run_opts  = s_nxt.cy_opts;
      tload = 1'b1;
      tlen  = seg_len(4'h0, s_nxt.cy_sel);
    end

    // Segment sequencing and end of the active phase.
    if (s_r.active && tdone) begin
      if (nx != vrmc_pkg::SEG_END) begin
        s_nxt.seg = nx;
        tload     = 1'b1;
        tlen      = seg_len(nx, s_r.run_sel);
      end else begin
        s_nxt.active = 1'b0;
        s_nxt.st     = vrmc_pkg::M_IDLE;
        s_nxt.start  = 1'b0;
        if (s_nxt.cyc_off_pend) begin
          s_nxt.cyc_en       = 1'b0;
          s_nxt.cyc_off_pend = 1'b0;
          s_nxt.tick_pend    = 1'b0;
        end else if (s_r.st == vrmc_pkg::M_OVR && s_r.cyc_en) begin
          s_nxt.locked = 1'b1;
        end
      end
    end

    // Override wins over every other event of the cycle.
    if (ovr_req_i && s_r.active && s_r.st != vrmc_pkg::M_OVR) begin
      s_nxt.st       = vrmc_pkg::M_OVR;
      s_nxt.latch    = 1'b1;
      s_nxt.active   = 1'b1;
      s_nxt.start    = s_r.start;
      s_nxt.seg      = 4'h0;
      s_nxt.run_sel  = s_r.run_sel;
      s_nxt.run_opts = vrmc_pkg::OPTS_ALL;
      tload = 1'b1;
      tlen  = seg_len(4'h0, s_r.run_sel);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_r          <= '0;
      s_r.st       <= vrmc_pkg::M_IDLE;
      s_r.od_sel   <= vrmc_pkg::SEL_RST;
      s_r.cy_sel   <= vrmc_pkg::SEL_RST;
      s_r.cy_opts  <= vrmc_pkg::OPTS_RST;
      s_r.run_opts <= vrmc_pkg::OPTS_RST;
      s_r.period   <= vrmc_pkg::PERIOD_RST;
      s_r.waitreq  <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata_o    = s_r.rdata;
  assign avs_waitrequest_o = s_r.waitreq;
  assign active_o          = s_r.active;
  assign seg_o             = s_r.seg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [LEN_W+3:0] act_len;
  logic             ovr_seen;
  logic [LEN_W+3:0] max_len;

  assign max_len = ((LEN_W+4)'(win(s_r.run_sel)) << 2) + (LEN_W+4)'(5 * BASE_CYC)
                 + (LEN_W+4)'(2 * BSET_CYC) + (LEN_W+4)'(2 * CSET_CYC) + (LEN_W+4)'(GSET_CYC);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !s_r.active) begin
      act_len  <= '0;
      ovr_seen <= 1'b0;
    end else begin
      act_len  <= act_len + (LEN_W+4)'(1);
      ovr_seen <= ovr_seen || (s_r.st == vrmc_pkg::M_OVR);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence run_ends;
    $fell(s_r.active);
  endsequence

  chk_min_run: assert property (run_ends ##0 (!$past(ovr_seen) && $past(s_r.run_opts) == 5'h00)
      |-> act_len == ((LEN_W+4)'(win($past(s_r.run_sel))) << 1))
    else $error("mandatory-only run length wrong");
  chk_max_run: assert property (s_r.active && !ovr_seen |-> act_len < max_len)
    else $error("active phase longer than the full routine");
  chk_od_window: assert property ($rose(s_r.start) |-> s_r.run_sel == s_r.od_sel)
    else $error("on-demand run took the wrong window");
  chk_cyc_window: assert property ($rose(s_r.st == vrmc_pkg::M_CYC)
      |-> s_r.run_sel == s_r.cy_sel)
    else $error("cyclic run took the wrong window");
  chk_one_mode: assert property ($onehot(s_r.st))
    else $error("more than one routine mode active");
  chk_ovr_preempt: assert property (ovr_req_i && s_r.active && s_r.st != vrmc_pkg::M_OVR
      |=> s_r.st == vrmc_pkg::M_OVR && s_r.latch && s_r.seg == 4'h0)
    else $error("override did not preempt the routine");
  chk_ovr_end_idle: assert property (s_r.st == vrmc_pkg::M_OVR && tdone && nx == vrmc_pkg::SEG_END
      && !ovr_req_i |=> s_r.st == vrmc_pkg::M_IDLE && !s_r.active && s_r.latch)
    else $error("override did not end idle with latch set");
  chk_no_restart: assert property (s_r.st inside {vrmc_pkg::M_OD, vrmc_pkg::M_OVR}
      && s_r.seg != 4'h0 && !ovr_req_i |=> s_r.seg != 4'h0)
    else $error("running routine was restarted");
  chk_read_status: assert property (avs_read_i && s_r.waitreq && avs_address_i == vrmc_pkg::OFF_CTRL
      |=> avs_readdata_o[3:0] == $past({s_r.active, s_r.cyc_en, s_r.latch, s_r.start}))
    else $error("control readback does not show status");
  chk_lock_hold: assert property (s_r.locked
      |-> s_r.st == vrmc_pkg::M_IDLE && s_r.latch && s_r.cyc_en && !s_r.active)
    else $error("locked cyclic state inconsistent");
  chk_ovr_status: assert property (s_r.st == vrmc_pkg::M_OVR
      |-> s_r.latch && s_r.active && (s_r.start || s_r.cyc_en))
    else $error("override status bits wrong");
  chk_no_orphan: assert property ((s_r.active |-> (s_r.start || s_r.cyc_en))
      and (s_r.start |-> s_r.active))
    else $error("impossible status combination");
  chk_start_clear: assert property ($fell(s_r.start) |-> $fell(s_r.active))
    else $error("start cleared outside routine end");
  chk_active_steps: assert property (s_r.active == (s_r.st != vrmc_pkg::M_IDLE))
    else $error("active flag does not match execution");

endmodule : vrmc_ctrl
`default_nettype wire

// *** logic/vrmc_period_tmr.sv ***
// Free counter that marks each routine period while cyclic mode runs.
`timescale 1ns/1ns
`default_nettype none
module vrmc_period_tmr #(
  parameter int W = 24
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Period control
  input  wire logic         run_i,
  input  wire logic [W-1:0] period_i,
  output logic              expire_o
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } vrmc_pst_t;

  vrmc_pst_t s_r;
  vrmc_pst_t s_nxt;
  logic      last;

  // A period of zero behaves as one cycle rather than wrapping round.
  assign last     = (s_r.cnt + W'(1) >= period_i);
  assign expire_o = run_i && last;

  always_comb begin
    s_nxt = s_r;
    if (!run_i || last) begin
      s_nxt.cnt = '0;
    end else begin
      s_nxt.cnt = s_r.cnt + W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : vrmc_period_tmr
`default_nettype wire

// *** logic/vrmc_pkg.sv ***
// Constants, types and helper functions of the voltage routine mode control block.
//
// Contract
// - Mandatory-only run lasts two selected windows.
// - Full run bounded by documented window and settle sum.
// - Window select: on-demand field or cyclic field.
// - One routine instance at a time.
// - Override preempts any on-demand or cyclic run, then ends idle.
// - On-demand never preempts on-demand or override.
// - Override may preempt cyclic activity.
// - Control readback shows start, latch, enable, active.
// - Status bits decode the routine state.
// - Latch alone means idle after override.
// - Latch plus enable locks cyclic idle.
// - Latch, enable, active: override during cyclic.
// - Start, latch, active: on-demand after fault.
// - Start holds for whole run, cleared at end.
// - Active flag high exactly while steps run.
`default_nettype none
package vrmc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] OFF_CTRL   = 4'h0;
  localparam logic [3:0] OFF_PERIOD = 4'h4;
  localparam logic [3:0] OFF_INFO   = 4'h8;

  localparam int CTRL_START  = 0;
  localparam int CTRL_LATCH  = 1;
  localparam int CTRL_CYC    = 2;
  localparam int CTRL_ACTIVE = 3;
  localparam int CTRL_ODSEL  = 4;
  localparam int CTRL_CYSEL  = 8;
  localparam int CTRL_OPTS   = 12;
  localparam int CTRL_CYOPTS = 20;
  localparam int INFO_LOCK   = 4;

  localparam logic [2:0]  SEL_RST    = 3'h0;
  localparam logic [4:0]  OPTS_RST   = 5'h00;
  localparam logic [4:0]  OPTS_ALL   = 5'h1F;
  localparam logic [23:0] PERIOD_RST = 24'h00_4E20;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS      = 50;
  localparam int WIN_BASE_NS = 10000;
  localparam int GSET_NS     = 5000;
  localparam int CSET_NS     = 8000;
  localparam int BSET_NS     = 6000;
  localparam int WIN_BASE_CYC = (WIN_BASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int GSET_CYC     = (GSET_NS + CLK_NS - 1) / CLK_NS;
  localparam int CSET_CYC     = (CSET_NS + CLK_NS - 1) / CLK_NS;
  localparam int BSET_CYC     = (BSET_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------
  // Routine segments
  // ----------------------------------------------------------------
  localparam int         NSEG    = 14;
  localparam logic [3:0] SEG_END = 4'hF;

  typedef enum logic [3:0] {
    M_IDLE = 4'b0001,
    M_OD   = 4'b0010,
    M_CYC  = 4'b0100,
    M_OVR  = 4'b1000
  } vrmc_mode_t;

  typedef enum logic [4:0] {
    K_SEL   = 5'b00001,
    K_SHORT = 5'b00010,
    K_GSET  = 5'b00100,
    K_CSET  = 5'b01000,
    K_BSET  = 5'b10000
  } vrmc_kind_t;

  function automatic vrmc_kind_t seg_kind(input logic [3:0] idx);
    vrmc_kind_t k;
    k = K_SHORT;
    case (idx)
      4'h0, 4'h1, 4'h2, 4'hD: k = K_SEL;
      4'h3:                   k = K_GSET;
      4'h5, 4'h7:             k = K_CSET;
      4'h9, 4'hB:             k = K_BSET;
      default:                k = K_SHORT;
    endcase
    return k;
  endfunction : seg_kind

  // Bits of opts: gpio, gpio terminal, cell terminal, balance terminal, self-check.
  function automatic logic seg_on(input logic [3:0] idx, input logic [4:0] opts);
    logic r;
    r = 1'b0;
    case (idx)
      4'h0, 4'h1:                   r = 1'b1;
      4'h2:                         r = opts[0];
      4'h3, 4'h4:                   r = opts[1];
      4'h5, 4'h6, 4'h7, 4'h8:       r = opts[2];
      4'h9, 4'hA, 4'hB, 4'hC:       r = opts[3];
      4'hD:                         r = opts[4];
      default:                      r = 1'b0;
    endcase
    return r;
  endfunction : seg_on

  function automatic logic [3:0] next_seg(input logic [3:0] cur, input logic [4:0] opts);
    logic [3:0] r;
    logic       hit;
    r   = SEG_END;
    hit = 1'b0;
    for (int i = 0; i < NSEG; i++) begin
      if (!hit && (4'(i) > cur) && seg_on(4'(i), opts)) begin
        r   = 4'(i);
        hit = 1'b1;
      end
    end
    return r;
  endfunction : next_seg

endpackage : vrmc_pkg
`default_nettype wire

// *** logic/vrmc_win_tmr.sv ***
// Down counter that times one routine segment.
`timescale 1ns/1ns
`default_nettype none
module vrmc_win_tmr #(
  parameter int LEN_W = 24
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Segment control
  input  wire logic             load_i,
  input  wire logic [LEN_W-1:0] len_i,
  output logic                  done_o
);

  typedef struct packed {
    logic [LEN_W-1:0] cnt;
  } vrmc_wst_t;

  vrmc_wst_t s_r;
  vrmc_wst_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (load_i) begin
      s_nxt.cnt = len_i;
    end else if (s_r.cnt != '0) begin
      s_nxt.cnt = s_r.cnt - LEN_W'(1);
    end
  end

  // The last cycle of a segment is the one with one count left.
  assign done_o = (s_r.cnt == LEN_W'(1));

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : vrmc_win_tmr
`default_nettype wire

// *** verif/voltage_routine_mode_control_bench.sv ***
// Self-checking bench of the routine mode control.
`timescale 1ns/1ns
`default_nettype none
module voltage_routine_mode_control_bench;
  logic        clk_i;
  logic        rst_n_i;
  logic [3:0]  adr;
  logic        rd;
  logic        wr;
  logic [31:0] wd;
  logic [3:0]  be;
  logic [31:0] rdat;
  logic        wreq;
  logic        ovr_req_i;
  logic        active;
  logic [3:0]  seg;
  int          n_errors;
  int          num_checks;
  int          cnt;
  int          run_len;

  vrmc_host host (.clk_i(clk_i), .avs_address_o(adr), .avs_read_o(rd), .avs_write_o(wr),
    .avs_writedata_o(wd), .avs_byteenable_o(be), .avs_readdata_i(rdat),
    .avs_waitrequest_i(wreq));

  vrmc_ctrl #(.BASE_CYC(4), .GSET_CYC(2), .CSET_CYC(3), .BSET_CYC(2)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .ovr_req_i(ovr_req_i),
    .active_o(active), .seg_o(seg));

  // ----------------------------------------------------------------
  // Clock, reset and run-length monitor
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // An override restarts the run, so the count starts again there.
  always @(posedge clk_i) begin
    if (ovr_req_i === 1'b1) cnt <= 0;
    else if (active === 1'b1) cnt <= cnt + 1;
    else if (cnt != 0) begin
      run_len <= cnt;
      cnt     <= 0;
    end
  end

  // ----------------------------------------------------------------
  // Checking and verdict
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] q;
    host.acc(1'b0, a, 32'h0000_0000, q);
    cmp(q & m, exp, "readback");
  endtask : rd_chk

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.acc(1'b1, a, d, q);
  endtask : wr_reg

  task automatic ovr_pulse();
    @(posedge clk_i);
    ovr_req_i <= 1'b1;
    @(posedge clk_i);
    ovr_req_i <= 1'b0;
  endtask : ovr_pulse

  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    give_verdict();
  end

  initial begin
    rst_n_i   = 1'b0;
    ovr_req_i = 1'b0;
    cnt       = 0;
    run_len   = 0;
    n_errors  = 0;
    num_checks = 0;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd_chk(4'h0, 32'h0000_000F, 32'h0000_0000);
    rd_chk(4'h4, 32'hFFFF_FFFF, 32'h0000_4E20);
    rd_chk(4'hC, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("test reset done");
    // On-demand mandatory run, with a second start refused mid-run.
    wr_reg(4'h0, 32'h0000_0001);
    rd_chk(4'h0, 32'h0000_000F, 32'h0000_0009);
    wr_reg(4'h0, 32'h0001_F001);
    host.poll_idle();
    cmp(run_len, 32'd8, "mandatory run length");
    rd_chk(4'h0, 32'h0000_000F, 32'h0000_0000);
    wr_reg(4'h0, 32'h0000_0011);
    host.poll_idle();
    cmp(run_len, 32'd16, "on-demand window select");
    wr_reg(4'h0, 32'h0001_F001);
    host.poll_idle();
    cmp(run_len, 32'd48, "full run length");
    $display("test on-demand done");
    // Override during an on-demand run.
    wr_reg(4'h0, 32'h0000_0001);
    ovr_pulse();
    rd_chk(4'h0, 32'h0000_000F, 32'h0000_000B);
    host.poll_idle();
    cmp(run_len, 32'd48, "override run length");
    rd_chk(4'h0, 32'h0000_000F, 32'h0000_0002);
    wr_reg(4'h0, 32'h0000_0002);
    rd_chk(4'h0, 32'h0000_000F, 32'h0000_0000);
    $display("test override done");
    // Cyclic runs, then an override that locks them.
    wr_reg(4'h4, 32'h0000_0064);
    wr_reg(4'h0, 32'h0000_0104);
    rd_chk(4'h0, 32'h0000_000F, 32'h0000_000C);
    host.poll_idle();
    cmp(run_len, 32'd16, "cyclic window select");
    rd_chk(4'h0, 32'h0000_000F, 32'h0000_0004);
    while (active !== 1'b1) @(posedge clk_i);
    ovr_pulse();
    rd_chk(4'h0, 32'h0000_000F, 32'h0000_000E);
    host.poll_idle();
    cmp(run_len, 32'd64, "override of cyclic run");
    rd_chk(4'h0, 32'h0000_000F, 32'h0000_0006);
    repeat (250) @(posedge clk_i);
    rd_chk(4'h0, 32'h0000_000F, 32'h0000_0006);
    cmp(run_len, 32'd64, "no run while locked");
    rd_chk(4'h8, 32'h0000_001F, 32'h0000_001D);
    cmp({28'h000_0000, seg}, 32'h0000_000D, "segment index");
    wr_reg(4'h0, 32'h0000_0006);
    rd_chk(4'h0, 32'h0000_000F, 32'h0000_0006);
    wr_reg(4'h0, 32'h0000_0000);
    rd_chk(4'h0, 32'h0000_000F, 32'h0000_0002);
    wr_reg(4'h0, 32'h0000_0002);
    rd_chk(4'h0, 32'h0000_000F, 32'h0000_0000);
    wr_reg(4'h0, 32'h0000_0004);
    wr_reg(4'h0, 32'h0000_0000);
    rd_chk(4'h0, 32'h0000_000F, 32'h0000_000C);
    host.poll_idle();
    rd_chk(4'h0, 32'h0000_000F, 32'h0000_0000);
    cmp(run_len, 32'd8, "cyclic disable waits for run end");
    $display("test cyclic done");
    give_verdict();
  end
endmodule : voltage_routine_mode_control_bench
`default_nettype wire

// *** verif/vrmc_host.sv ***
// Host model: Avalon-MM master that reaches the routine registers and polls the status.
`timescale 1ns/1ns
`default_nettype none
module vrmc_host (
  // Clock
  input  wire logic        clk_i,
  // Avalon-MM master
  output logic [3:0]       avs_address_o,
  output logic             avs_read_o,
  output logic             avs_write_o,
  output logic [31:0]      avs_writedata_o,
  output logic [3:0]       avs_byteenable_o,
  input  wire logic [31:0] avs_readdata_i,
  input  wire logic        avs_waitrequest_i
);
  initial begin
    avs_address_o    = 4'h0;
    avs_read_o       = 1'b0;
    avs_write_o      = 1'b0;
    avs_writedata_o  = 32'h0000_0000;
    avs_byteenable_o = 4'hF;
  end

  task automatic acc(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_i);
    avs_address_o   <= a;
    avs_read_o      <= !wr;
    avs_write_o     <= wr;
    avs_writedata_o <= d;
    do @(posedge clk_i); while (avs_waitrequest_i !== 1'b0);
    q = avs_readdata_i;
    avs_read_o  <= 1'b0;
    avs_write_o <= 1'b0;
  endtask : acc

  // Polls until the active flag reads low, so a new mode is never asked for mid-run.
  task automatic poll_idle();
    logic [31:0] q;
    q = 32'hFFFF_FFFF;
    while (q[3] !== 1'b0) acc(1'b0, 4'h0, 32'h0000_0000, q);
  endtask : poll_idle
endmodule : vrmc_host
`default_nettype wire
